// ===== verilog/dcpm_ctrl.sv
// Operating mode, clock selection, reset and configuration word control
// ****************************************
// What this block does
// - Power-on loads register defaults; clock, drop level, protection come from config word.
// - Hold static reset while supply sits below the configured drop level.
// - Pin and dog resets enabled by config; restore defaults, keep timeout flags.
// - Config word sits at FFCh, programmer-written only, upper nine bits default one.
// - Config bit 13 low hides true program memory from external read-out.
// - Lock with reuse_n high guards first half; reuse_n low guards all but reserved.
// - Start in FAST after any reset; config [9:8] picks the fast source.
// - Any of six sources may clock the CPU; IDLE keeps only slow clock.
// - FAST clocks CPU and peripherals fast while halt is zero; timer fast only with pick one, select zero.
// - SLOW runs CPU and peripherals from chosen slow source, fast clock stopped.
// - Sleep with slow enabled and timer pick zero enters IDLE.
// - Sleep with slow disabled enters STOP; both oscillators powered down.
// - Slow oscillator keeps running in FAST while its enable stays set.
// - IDLE wakes on external, port B, wake timer or interval timer interrupts.
// - STOP wakes on external, port B or wake timer, never interval timer.
// - CPU clock divided by two for the instruction phases.
// ****************************************
module dcpm_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Supply monitors and reset pins
  input wire logic below_drop_level_high,
  input wire logic below_drop_level_mid,
  input wire logic below_drop_level_low,
  input wire logic ext_reset_n,
  input wire logic dog_timer_expired,
  // Configuration word read port
  input wire logic [13:0] cfg_data,
  output logic [11:0] cfg_addr,
  output logic cfg_read,
  // Clock setup register write from CPU
  input wire logic clock_setup_wr,
  input wire logic [4:0] clock_setup_wdata,
  output logic [4:0] clock_setup_reg,
  // Sleep instruction and wake sources
  input wire logic sleep_exec,
  input wire logic external_interrupt,
  input wire logic port_b_low_wake,
  input wire logic wake_interval_timer,
  input wire logic interval_timer_irq,
  // Source ticks
  input wire logic fast_tick,
  input wire logic slow_tick,
  // External program memory read-out
  input wire logic [11:0] dump_addr,
  input wire logic [13:0] dump_rom_data,
  output logic [13:0] dump_data,
  // Mode, reset and status
  output dcpm_pkg::dcpm_mode_type mode,
  output dcpm_pkg::dcpm_src_type cpu_source,
  output logic sys_reset_n,
  output logic por_reset_n,
  output logic [13:0] boot_configuration_word,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic cpu_clock,
  output logic cpu_phase,
  output logic periph_clock,
  output logic itimer_clock
);
  import dcpm_pkg::*;
  `include "dcpm_defs.svh"

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [4:0] pins_raw;
  logic [4:0] pins;
  assign pins_raw = {below_drop_level_high, below_drop_level_mid, below_drop_level_low,
    ext_reset_n, dog_timer_expired};

  dcpm_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // ****************************************
  // Configuration word fetch after power-on
  // ****************************************
  logic cfg_loaded;

  assign cfg_addr = `DCPM_CFG_ADDR;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_loaded <= 1'b0;
      cfg_read <= 1'b0;
      boot_configuration_word <= `DCPM_CFG_DEFAULT;
    end else if (!cfg_loaded) begin
      cfg_read <= ~cfg_read;
      if (cfg_read) begin
        boot_configuration_word <= cfg_data;
        cfg_loaded <= 1'b1;
      end
    end else begin
      cfg_read <= 1'b0;
    end
  end

  // ****************************************
  // Reset sources
  // ****************************************
  logic [1:0] drop_sel;
  logic below_drop;
  logic warm_req;
  logic [3:0] stretch;

  assign drop_sel = boot_configuration_word[`DCPM_CFG_DROP_HI:`DCPM_CFG_DROP_LO];

  always_comb begin
    case (drop_sel)
      `DCPM_DROP_HIGH: below_drop = pins[4];
      `DCPM_DROP_MID: below_drop = pins[3];
      default: below_drop = pins[2];
    endcase
  end

  // Dog and pin resets only count when the word allows them
  assign warm_req = below_drop
    || (boot_configuration_word[`DCPM_CFG_XRST_EN_BIT] && !pins[1])
    || (boot_configuration_word[`DCPM_CFG_DOG_EN_BIT] && pins[0]);

  // Stretched so that a short glitch still clears every control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stretch <= `DCPM_RST_STRETCH;
    end else if (warm_req || !cfg_loaded) begin
      stretch <= `DCPM_RST_STRETCH;
    end else if (stretch != 4'h0) begin
      stretch <= stretch - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_reset_n <= 1'b0;
      por_reset_n <= 1'b0;
    end else begin
      sys_reset_n <= (stretch == 4'h0) && !warm_req;
      // Timeout flags live behind this reset, so warm resets leave them
      por_reset_n <= cfg_loaded;
    end
  end

  // ****************************************
  // Clock setup register
  // ****************************************
  // Fields: [4] pick, [3] halt, [2] select, [1:0] slow source
  logic slow_osc_enable;
  logic slow_clock_select;
  logic fast_osc_halt;
  logic interval_timer_clock_pick;
  logic [1:0] slow_source_field;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clock_setup_reg <= `DCPM_CLK_SETUP_RESET;
      slow_osc_enable <= 1'b0;
    end else if (!sys_reset_n) begin
      clock_setup_reg <= `DCPM_CLK_SETUP_RESET;
      slow_osc_enable <= 1'b0;
    end else if (clock_setup_wr && (mode == dcpm_fast || mode == dcpm_slow)) begin
      clock_setup_reg <= clock_setup_wdata;
      slow_osc_enable <= clock_setup_wdata[2] | clock_setup_wdata[4] ? 1'b1 : 1'b0;
    end
  end

  assign interval_timer_clock_pick = clock_setup_reg[4];
  assign fast_osc_halt = clock_setup_reg[3];
  assign slow_clock_select = clock_setup_reg[2] && slow_osc_enable;
  assign slow_source_field = clock_setup_reg[1:0];

  // ****************************************
  // Operating mode machine
  // ****************************************
  dcpm_mode_type next_mode;
  logic wake_idle;
  logic wake_stop;

  assign wake_idle = external_interrupt || port_b_low_wake || wake_interval_timer
    || interval_timer_irq;
  assign wake_stop = external_interrupt || port_b_low_wake || wake_interval_timer;

  always_comb begin
    next_mode = mode;
    case (mode)
      dcpm_fast, dcpm_slow: begin
        if (sleep_exec && slow_osc_enable && !interval_timer_clock_pick) begin
          next_mode = dcpm_idle;
        end else if (sleep_exec && !slow_osc_enable) begin
          next_mode = dcpm_stop;
        end else if (slow_clock_select) begin
          next_mode = dcpm_slow;
        end else begin
          next_mode = dcpm_fast;
        end
      end
      dcpm_idle: begin
        // Setup bits were frozen during sleep, so the old selection returns
        if (wake_idle) begin
          next_mode = slow_clock_select ? dcpm_slow : dcpm_fast;
        end
      end
      dcpm_stop: begin
        if (wake_stop) begin
          next_mode = slow_clock_select ? dcpm_slow : dcpm_fast;
        end
      end
      default: next_mode = dcpm_fast;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= dcpm_fast;
    end else if (!sys_reset_n) begin
      mode <= dcpm_fast;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // Source selection and oscillator power
  // ****************************************
  dcpm_src_type fast_src;
  dcpm_src_type slow_src;

  function automatic dcpm_src_type fast_decode(input logic [1:0] sel);
    case (sel)
      `DCPM_FSRC_CRYSTAL: fast_decode = dcpm_src_fast_crystal;
      `DCPM_FSRC_INT_RC: fast_decode = dcpm_src_fast_int_rc;
      default: fast_decode = dcpm_src_ext_rc;
    endcase
  endfunction : fast_decode

  always_comb begin
    fast_src = fast_decode(boot_configuration_word[`DCPM_CFG_FSRC_HI:`DCPM_CFG_FSRC_LO]);
    case (slow_source_field)
      2'h0: slow_src = dcpm_src_slow_crystal;
      2'h1: slow_src = dcpm_src_ext_rc;
      2'h2: slow_src = dcpm_src_slow_int_rc;
      default: slow_src = dcpm_src_touch;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_source <= dcpm_src_fast_crystal;
      fast_osc_on <= 1'b1;
      slow_osc_on <= 1'b0;
    end else begin
      cpu_source <= (mode == dcpm_slow) ? slow_src : fast_src;
      fast_osc_on <= (mode == dcpm_fast || mode == dcpm_slow) && !fast_osc_halt
        && mode != dcpm_slow;
      slow_osc_on <= slow_osc_enable && mode != dcpm_stop;
    end
  end

  // ****************************************
  // Clock routing
  // ****************************************
  dcpm_gate_if gate ();

  assign gate.fast_run = fast_osc_on;
  assign gate.slow_run = slow_osc_on;
  assign gate.cpu_run = (mode == dcpm_fast || mode == dcpm_slow) && sys_reset_n;
  assign gate.periph_run = gate.cpu_run;
  assign gate.use_slow = (mode == dcpm_slow);
  assign gate.itimer_fast = interval_timer_clock_pick && !slow_clock_select;
  assign gate.itimer_run = (mode != dcpm_stop) && sys_reset_n;

  dcpm_route u_route (
    .clk(clk),
    .nrst(nrst),
    .gate(gate.route),
    .fast_tick(fast_tick),
    .slow_tick(slow_tick),
    .cpu_clock(cpu_clock),
    .cpu_phase(cpu_phase),
    .periph_clock(periph_clock),
    .itimer_clock(itimer_clock)
  );

  // ****************************************
  // Code protection on read-out
  // ****************************************
  logic lock_hit;

  always_comb begin
    lock_hit = 1'b0;
    if (!boot_configuration_word[`DCPM_CFG_LOCK_BIT]) begin
      if (boot_configuration_word[`DCPM_CFG_REUSE_BIT]) begin
        lock_hit = dump_addr < `DCPM_HALF_ADDR;
      end else begin
        lock_hit = dump_addr < `DCPM_RESERVED_ADDR;
      end
    end
  end

  // Protected words read as all ones, a value no tool takes as code
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dump_data <= 14'h3fff;
    end else begin
      dump_data <= lock_hit ? 14'h3fff : dump_rom_data;
    end
  end
endmodule : dcpm_ctrl

// ===== inc/dcpm_defs.svh
// Offsets, field positions, reset values and timing counts of the mode controller
`ifndef DCPM_DEFS_SVH
`define DCPM_DEFS_SVH
`define DCPM_CFG_ADDR 12'hffc
`define DCPM_CFG_WIDTH 14
`define DCPM_CFG_LOCK_BIT 13
`define DCPM_CFG_REUSE_BIT 12
`define DCPM_CFG_XRST_EN_BIT 11
`define DCPM_CFG_DOG_EN_BIT 10
`define DCPM_CFG_FSRC_HI 9
`define DCPM_CFG_FSRC_LO 8
`define DCPM_CFG_DROP_HI 7
`define DCPM_CFG_DROP_LO 6
`define DCPM_CFG_DEFAULT 14'h3fe0
`define DCPM_FSRC_CRYSTAL 2'h3
`define DCPM_FSRC_EXT_RC 2'h0
`define DCPM_FSRC_INT_RC 2'h1
`define DCPM_DROP_HIGH 2'h0
`define DCPM_DROP_MID 2'h1
`define DCPM_DROP_LOW 2'h2
`define DCPM_HALF_ADDR 12'h800
`define DCPM_REUSE_VECTOR 12'h200
`define DCPM_RESERVED_ADDR 12'hff0
`define DCPM_CLK_SETUP_RESET 5'h04
`define DCPM_RST_STRETCH 4'h8
`endif

// ===== inc/dcpm_pkg.sv
// Types of the mode controller
package dcpm_pkg;
  typedef enum logic [1:0] {
    dcpm_fast = 2'h0,
    dcpm_slow = 2'h1,
    dcpm_idle = 2'h3,
    dcpm_stop = 2'h2
  } dcpm_mode_type;
  typedef enum logic [2:0] {
    dcpm_src_fast_crystal = 3'h0,
    dcpm_src_ext_rc = 3'h1,
    dcpm_src_fast_int_rc = 3'h2,
    dcpm_src_slow_crystal = 3'h3,
    dcpm_src_slow_int_rc = 3'h4,
    dcpm_src_touch = 3'h5
  } dcpm_src_type;
endpackage : dcpm_pkg

// ===== inc/dcpm_gate_if.sv
// Gate enables passed from the mode controller to its clock router
interface dcpm_gate_if;
  logic fast_run;
  logic slow_run;
  logic cpu_run;
  logic periph_run;
  logic use_slow;
  logic itimer_fast;
  logic itimer_run;
  modport ctrl (output fast_run, slow_run, cpu_run, periph_run, use_slow, itimer_fast,
    itimer_run);
  modport route (input fast_run, slow_run, cpu_run, periph_run, use_slow, itimer_fast,
    itimer_run);
endinterface : dcpm_gate_if

// ===== verilog/dcpm_sync.sv
// Two-stage synchroniser for asynchronous pin levels
module dcpm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : dcpm_sync

// ===== verilog/dcpm_route.sv
// Clock enable router: CPU phases and peripheral enables from the mode gates
module dcpm_route (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Gates
  dcpm_gate_if.route gate,
  // Source ticks
  input wire logic fast_tick,
  input wire logic slow_tick,
  // Enables
  output logic cpu_clock,
  output logic cpu_phase,
  output logic periph_clock,
  output logic itimer_clock
);
  logic cpu_src;

  assign cpu_src = gate.cpu_run &&
    (gate.use_slow ? (slow_tick && gate.slow_run) : (fast_tick && gate.fast_run));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_clock <= 1'b0;
      periph_clock <= 1'b0;
      itimer_clock <= 1'b0;
    end else begin
      cpu_clock <= cpu_src;
      periph_clock <= gate.periph_run && cpu_src;
      itimer_clock <= gate.itimer_run &&
        (gate.itimer_fast ? (fast_tick && gate.fast_run) : (slow_tick && gate.slow_run));
    end
  end

  // Two CPU clocks make one instruction cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_phase <= 1'b0;
    end else if (cpu_src) begin
      cpu_phase <= ~cpu_phase;
    end
  end
endmodule : dcpm_route

// ===== sim/dcpm_monitor.sv
// Port checker for the mode controller, bound to its top module
module dcpm_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic [11:0] cfg_addr,
  input wire logic clock_setup_wr,
  input wire logic [4:0] clock_setup_wdata,
  input wire logic [4:0] clock_setup_reg,
  input wire logic external_interrupt,
  input wire logic port_b_low_wake,
  input wire logic wake_interval_timer,
  input wire logic interval_timer_irq,
  input wire logic [11:0] dump_addr,
  input wire logic [13:0] dump_data,
  input wire logic [13:0] boot_configuration_word,
  input wire logic [1:0] mode,
  input wire logic sys_reset_n,
  input wire logic por_reset_n,
  input wire logic fast_osc_on,
  input wire logic slow_osc_on,
  input wire logic cpu_clock,
  input wire logic cpu_phase,
  input wire logic periph_clock,
  input wire logic itimer_clock
);
  import dcpm_pkg::*;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  cfg_addr_fixed_a: assert property (cfg_addr == 12'hffc)
    else $error("config address moved");
  setup_write_taken_a: assert property (
    clock_setup_wr && sys_reset_n && mode inside {dcpm_fast, dcpm_slow}
    |=> clock_setup_reg == $past(clock_setup_wdata))
    else $error("clock setup write lost");
  por_before_sys_a: assert property (!por_reset_n |-> !sys_reset_n)
    else $error("system reset left before power-on reset");
  // Two edges back, since the oscillators follow the mode one edge late
  fast_osc_live_a: assert property (
    sys_reset_n && mode == dcpm_fast && $past(mode, 2) == dcpm_fast |-> fast_osc_on)
    else $error("fast oscillator off in fast mode");
  stop_no_clock_a: assert property (
    mode == dcpm_stop && $past(mode, 2) == dcpm_stop
    |-> !fast_osc_on && !slow_osc_on && !cpu_clock && !periph_clock && !itimer_clock)
    else $error("clock alive in stop mode");
  idle_slow_only_a: assert property (
    mode == dcpm_idle && $past(mode, 2) == dcpm_idle
    |-> slow_osc_on && !cpu_clock && !periph_clock)
    else $error("idle mode clocks wrong");
  stop_holds_a: assert property (
    sys_reset_n && mode == dcpm_stop
    && !(external_interrupt || port_b_low_wake || wake_interval_timer) |=> mode == dcpm_stop)
    else $error("stop left without a wake source");
  idle_wakes_a: assert property (
    sys_reset_n && mode == dcpm_idle && interval_timer_irq |-> ##[1:6] mode != dcpm_idle)
    else $error("idle kept on timer interrupt");
  lock_hides_a: assert property (
    !boot_configuration_word[13] && boot_configuration_word[12] && dump_addr < 12'h800
    |=> dump_data == 14'h3fff)
    else $error("locked memory read out");
  phase_on_tick_a: assert property ($changed(cpu_phase) |-> cpu_clock)
    else $error("phase moved without cpu tick");
endmodule : dcpm_monitor

bind dcpm_ctrl dcpm_monitor mon (.*);

// ===== sim/tb_top.sv
// Self-checking bench for the mode controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dcpm_pkg::*;
  // ****
  // Bench
  // ****
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] wake = 4'h0;
  logic [3:0] hit = 4'h0;
  wire ext_reset_n = !hit[0];
  wire dog_timer_expired = hit[1];
  wire below_drop_level_mid = hit[2];
  wire below_drop_level_high = hit[3];
  wire below_drop_level_low = 1'b0;
  wire external_interrupt = wake[0];
  wire port_b_low_wake = wake[1];
  wire wake_interval_timer = wake[2];
  wire interval_timer_irq = wake[3];
  logic clock_setup_wr = 1'b0;
  logic sleep_exec = 1'b0;
  logic fast_tick = 1'b0;
  logic slow_tick = 1'b0;
  logic [1:0] cyc = 2'h0;
  logic [4:0] clock_setup_wdata = 5'h00;
  logic [11:0] dump_addr = 12'h000;
  logic [13:0] cfg_data = 14'h3fe0;
  logic [13:0] dump_rom_data = 14'h1a5c;
  logic cfg_read, sys_reset_n, por_reset_n, fast_osc_on, slow_osc_on;
  logic cpu_clock, cpu_phase, periph_clock, itimer_clock;
  logic [4:0] clock_setup_reg;
  logic [11:0] cfg_addr;
  logic [13:0] dump_data, boot_configuration_word;
  dcpm_mode_type mode;
  dcpm_src_type cpu_source;
  int err_total = 0;
  int n_checks = 0;
  // Slow sources per slow field value 3..0
  localparam logic [11:0] slow_src_tab = 12'hb0b;

  dcpm_ctrl dut (.*);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    fast_tick <= ~fast_tick;
    slow_tick <= (cyc == 2'h0);
  end

  task automatic conclude();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait on mode (sel high) or system reset
  task automatic wait_until(input logic sel, input logic [13:0] v);
    for (int i = 0; i < 40 && (sel ? 14'(mode) : 14'(sys_reset_n)) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(sel ? 14'(mode) : 14'(sys_reset_n), v);
    if (err_total > 0) conclude();
  endtask : wait_until

  task automatic wr(input logic [4:0] v);
    @(posedge clk);
    clock_setup_wr <= 1'b1;
    clock_setup_wdata <= v;
    @(posedge clk);
    clock_setup_wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : wr

  // Counts cpu, peripheral and timer pulses over eight cycles, a nibble each
  task automatic ticks(input logic [13:0] exp);
    logic [13:0] n;
    n = 14'h0;
    repeat (8) begin
      @(posedge clk);
      #1;
      n = n + {5'h0, cpu_clock, 3'h0, periph_clock, 3'h0, itimer_clock};
    end
    chk(n, exp);
  endtask : ticks

  task automatic power_on(input logic [13:0] cfg, input dcpm_src_type src);
    @(posedge clk);
    nrst <= 1'b0;
    cfg_data <= cfg;
    repeat (2) @(posedge clk);
    #1;
    chk({12'h0, sys_reset_n, por_reset_n}, 14'h0);
    chk(boot_configuration_word, 14'h3fe0);
    @(posedge clk);
    nrst <= 1'b1;
    wait_until(1'b0, 14'h1);
    chk(boot_configuration_word, cfg);
    chk(14'(cpu_source), 14'(src));
    chk({9'h0, clock_setup_reg}, 14'h04);
    chk({12'h0, mode == dcpm_fast, fast_osc_on}, 14'h3);
  endtask : power_on

  task automatic modes();
    wr(5'h10);
    chk({12'h0, slow_osc_on, fast_osc_on}, 14'h3);
    ticks(14'h0444);
    wr(5'h14);
    wr(5'h1c);
    for (int s = 0; s < 4; s++) begin
      wr(5'h0c | 5'(s));
      chk(14'(mode), 14'(dcpm_slow));
      chk(14'(cpu_source), 14'(slow_src_tab[3*s +: 3]));
      chk({12'h0, slow_osc_on, fast_osc_on}, 14'h2);
      ticks(14'h0222);
    end
    wr(5'h04);
    wr(5'h00);
    chk(14'(mode), 14'(dcpm_fast));
    chk({12'h0, slow_osc_on, fast_osc_on}, 14'h1);
  endtask : modes

  // Sleep, try a refused write, then wake on source k
  task automatic nap(input logic [4:0] setup, input int k, input dcpm_mode_type asleep,
      input dcpm_mode_type awake);
    wr(setup);
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    wait_until(1'b1, 14'(asleep));
    wr(5'h10);
    @(posedge clk);
    wake <= (asleep == dcpm_stop) ? 4'h8 : 4'h0;
    repeat (8) @(posedge clk);
    #1;
    chk(14'(mode), 14'(asleep));
    chk({9'h0, clock_setup_reg}, {9'h0, setup});
    ticks((asleep == dcpm_idle) ? 14'h0002 : 14'h0000);
    @(posedge clk);
    wake <= wake | (4'h1 << k);
    wait_until(1'b1, 14'(awake));
    @(posedge clk);
    wake <= 4'h0;
  endtask : nap

  task automatic hit_reset(input logic [3:0] h, input logic fires);
    wr(5'h0c);
    @(posedge clk);
    hit <= h;
    repeat (12) @(posedge clk);
    #1;
    chk({13'h0, sys_reset_n}, {13'h0, !fires});
    if (fires && !h[2]) chk({13'h0, por_reset_n}, 14'h1);
    @(posedge clk);
    hit <= 4'h0;
    wait_until(1'b0, 14'h1);
    chk({9'h0, clock_setup_reg}, fires ? 14'h04 : 14'h0c);
  endtask : hit_reset

  task automatic peek(input logic [11:0] a, input logic [13:0] exp);
    @(posedge clk);
    dump_addr <= a;
    repeat (3) @(posedge clk);
    #1;
    chk(dump_data, exp);
  endtask : peek

  initial begin
    power_on(14'h3ce0, dcpm_src_ext_rc);
    power_on(14'h3de0, dcpm_src_fast_int_rc);
    power_on(14'h3fe0, dcpm_src_fast_crystal);
    ticks(14'h0440);
    modes();
    for (int k = 0; k < 4; k++) nap(5'h0c, k, dcpm_idle, dcpm_slow);
    for (int k = 0; k < 3; k++) nap(5'h00, k, dcpm_stop, dcpm_fast);
    power_on(14'h3f60, dcpm_src_fast_crystal);
    hit_reset(4'h1, 1'b1);
    hit_reset(4'h2, 1'b1);
    hit_reset(4'h8, 1'b0);
    hit_reset(4'h4, 1'b1);
    power_on(14'h3360, dcpm_src_fast_crystal);
    hit_reset(4'h1, 1'b0);
    hit_reset(4'h2, 1'b0);
    power_on(14'h1fe0, dcpm_src_fast_crystal);
    peek(12'h100, 14'h3fff);
    peek(12'h900, 14'h1a5c);
    power_on(14'h0fe0, dcpm_src_fast_crystal);
    peek(12'h900, 14'h3fff);
    peek(12'h200, 14'h3fff);
    peek(12'hff4, 14'h1a5c);
    power_on(14'h3fe0, dcpm_src_fast_crystal);
    peek(12'h100, 14'h1a5c);
    conclude();
  end
endmodule : tb_top
